// *** fsr_pkg.sv ***
// fsr_pkg: constants, opcodes, state and carrier types for the flash
// suspend/resume sequencer.
// assumes a 200 MHz core clock; every user of it writes fsr_pkg::name.

package fsr_pkg;

   // clock and timing, times in microseconds
   localparam int CLK_MHZ              = 200;
   localparam int SUSPEND_LATENCY_US   = 20;
   localparam int RESUME_LATENCY_US    = 20;
   localparam int PROG_TIME_US         = 1000;
   localparam int ERASE_4K_TIME_US     = 50000;
   localparam int ERASE_32K_TIME_US    = 250000;
   localparam int ERASE_64K_TIME_US    = 400000;
   // longest times: rounding down to whole cycles is exact here
   localparam int SUSPEND_LATENCY_CYC  = SUSPEND_LATENCY_US * CLK_MHZ;
   localparam int RESUME_LATENCY_CYC   = RESUME_LATENCY_US * CLK_MHZ;
   localparam int PROG_CYC             = PROG_TIME_US * CLK_MHZ;
   localparam int ERASE_4K_CYC         = ERASE_4K_TIME_US * CLK_MHZ;
   localparam int ERASE_32K_CYC        = ERASE_32K_TIME_US * CLK_MHZ;
   localparam int ERASE_64K_CYC        = ERASE_64K_TIME_US * CLK_MHZ;

   // address layout
   localparam int ADDR_W     = 24;
   localparam int SECTOR_LSB = 16;
   localparam int SECTOR_W   = 8;
   localparam int CNT_W      = 32;
   localparam logic [2:0] ADDR_DONE_BYTES = 3'h4;
   localparam logic [2:0] PROG_MIN_BYTES  = 3'h5;

   // reset values
   localparam logic WEL_RST  = 1'b0;
   localparam logic FLAG_RST = 1'b0;

   // opcodes
   localparam logic [7:0] OP_SUSPEND   = 8'hb0;
   localparam logic [7:0] OP_RESUME    = 8'hd0;
   localparam logic [7:0] OP_WREN      = 8'h06;
   localparam logic [7:0] OP_WRDI      = 8'h04;
   localparam logic [7:0] OP_PROG      = 8'h02;
   localparam logic [7:0] OP_PROG_DUAL = 8'ha2;
   localparam logic [7:0] OP_ERASE_4K  = 8'h20;
   localparam logic [7:0] OP_ERASE_32K = 8'h52;
   localparam logic [7:0] OP_ERASE_64K = 8'hd8;
   localparam logic [7:0] OP_READ      = 8'h03;
   localparam logic [7:0] OP_READ_FAST = 8'h0b;
   localparam logic [7:0] OP_READ_HS   = 8'h1b;
   localparam logic [7:0] OP_READ_DUAL = 8'h3b;
   localparam logic [7:0] OP_RD_PROT   = 8'h3c;
   localparam logic [7:0] OP_RD_LOCK   = 8'h35;
   localparam logic [7:0] OP_RD_OTP    = 8'h77;
   localparam logic [7:0] OP_RD_STATUS = 8'h05;
   localparam logic [7:0] OP_RESET     = 8'hf0;
   localparam logic [7:0] OP_RD_ID     = 8'h9f;

   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_PROG   = 3'b001,
      ST_ERASE  = 3'b010,
      ST_SUSP   = 3'b011,
      ST_RESUME = 3'b100
   } fsr_state_e;

   // serial front-end events, one cycle each
   typedef struct packed {
      logic       byte_vld;
      logic [7:0] data;
      logic       frame_end;
      logic       aligned;
   } fsr_spi_evt_s;

endpackage : fsr_pkg

// *** fsr_seq.sv ***
// fsr_seq: program/erase suspend and resume sequencer of a serial flash.
// assumes the array engines are elsewhere; this block times the work,
// filters commands and passes allowed others on as a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none

module fsr_seq
#(
   parameter int PROG_CYCLES      = fsr_pkg::PROG_CYC,
   parameter int ERASE_4K_CYCLES  = fsr_pkg::ERASE_4K_CYC,
   parameter int ERASE_32K_CYCLES = fsr_pkg::ERASE_32K_CYC,
   parameter int ERASE_64K_CYCLES = fsr_pkg::ERASE_64K_CYC
)
(
   // clock and reset
   input  wire logic                         CLK,
   input  wire logic                         RST,
   // serial pins from the host
   input  wire logic                         SCK,
   input  wire logic                         CS_N,
   input  wire logic                         SI,
   // status flags
   output logic                              WRITE_ENABLE_LATCH,
   output logic                              PROGRAM_SUSPENDED_FLAG,
   output logic                              ERASE_SUSPENDED_FLAG,
   output logic                              READY_BUSY_FLAG,
   // array read tracking
   output logic                              READ_ACTIVE,
   output logic [fsr_pkg::ADDR_W-1:0]        READ_ADDR,
   output logic                              READ_DATA_UNDEF,
   // pass-through of other allowed commands
   output logic                              CMD_PASS,
   output logic [7:0]                        CMD_PASS_OPCODE,
   // cancellation reports
   output logic                              ERASE_BLOCK_UNDEF,
   output logic                              PROG_PAGE_UNDEF
);

   localparam int SW = fsr_pkg::SECTOR_W;
   localparam int CW = fsr_pkg::CNT_W;

   fsr_pkg::fsr_spi_evt_s evt;
   fsr_pkg::fsr_state_e   state_q;
   logic [7:0]            op_q;
   logic [fsr_pkg::ADDR_W-1:0] addr_q;
   logic [2:0]            nb_q;
   logic [CW-1:0]         cnt_q;
   logic [CW-1:0]         prog_rem_q;
   logic [CW-1:0]         erase_rem_q;
   logic                  run_prog_q;
   logic [SW-1:0]         erase_sec_q;
   logic [SW-1:0]         prog_sec_q;
   logic [SW-1:0]         cmd_sec;
   logic                  exec;
   logic                  allowed;
   logic                  idle;

   // byte-level front end
   fsr_spi_rx u_rx
   (
      .clk   (CLK),
      .rst   (RST),
      .sck   (SCK),
      .cs_n  (CS_N),
      .si    (SI),
      .evt_q (evt)
   );

   // which commands are legal in the present suspension
   function automatic logic op_allowed(input logic [7:0] op, input logic ps,
                                       input logic es);
      logic base;
      logic extra;
      base  = (op == fsr_pkg::OP_READ) || (op == fsr_pkg::OP_READ_FAST) ||
              (op == fsr_pkg::OP_READ_HS) || (op == fsr_pkg::OP_READ_DUAL) ||
              (op == fsr_pkg::OP_RESUME) || (op == fsr_pkg::OP_RD_PROT) ||
              (op == fsr_pkg::OP_RD_LOCK) || (op == fsr_pkg::OP_RD_OTP) ||
              (op == fsr_pkg::OP_RD_STATUS) || (op == fsr_pkg::OP_RESET) ||
              (op == fsr_pkg::OP_RD_ID);
      extra = (op == fsr_pkg::OP_PROG) || (op == fsr_pkg::OP_PROG_DUAL) ||
              (op == fsr_pkg::OP_SUSPEND) || (op == fsr_pkg::OP_WREN) ||
              (op == fsr_pkg::OP_WRDI);
      // while suspended, anything else, erases and protection included, is refused
      if (ps)
         return base;
      else if (es)
         return base | extra;
      else
         return 1'b1;
   endfunction : op_allowed

   function automatic logic is_read(input logic [7:0] op);
      return (op == fsr_pkg::OP_READ) || (op == fsr_pkg::OP_READ_FAST) ||
             (op == fsr_pkg::OP_READ_HS) || (op == fsr_pkg::OP_READ_DUAL);
   endfunction : is_read

   function automatic logic is_erase(input logic [7:0] op);
      return (op == fsr_pkg::OP_ERASE_4K) || (op == fsr_pkg::OP_ERASE_32K) ||
             (op == fsr_pkg::OP_ERASE_64K);
   endfunction : is_erase

   function automatic logic is_prog(input logic [7:0] op);
      return (op == fsr_pkg::OP_PROG) || (op == fsr_pkg::OP_PROG_DUAL);
   endfunction : is_prog

   function automatic logic [CW-1:0] erase_len(input logic [7:0] op);
      if (op == fsr_pkg::OP_ERASE_4K)
         return CW'(ERASE_4K_CYCLES);
      else if (op == fsr_pkg::OP_ERASE_32K)
         return CW'(ERASE_32K_CYCLES);
      else
         return CW'(ERASE_64K_CYCLES);
   endfunction : erase_len

   // a command acts only on a whole opcode ending on a byte boundary
   assign exec    = evt.frame_end & evt.aligned & (nb_q != 3'h0);
   assign allowed = op_allowed(op_q, PROGRAM_SUSPENDED_FLAG, ERASE_SUSPENDED_FLAG);
   assign idle    = (state_q == fsr_pkg::ST_IDLE);
   assign cmd_sec = addr_q[fsr_pkg::ADDR_W-1:fsr_pkg::SECTOR_LSB];

   // opcode and address capture; bytes past the address are only counted
   always_ff @(posedge CLK)
   begin
      if (RST || evt.frame_end)
      begin
         nb_q   <= 3'h0;
         op_q   <= 8'h00;
         addr_q <= '0;
      end
      else if (evt.byte_vld)
      begin
         if (nb_q != 3'h7)
            nb_q <= nb_q + 3'h1;
         if (nb_q == 3'h0)
            op_q <= evt.data;
         else if (nb_q < fsr_pkg::ADDR_DONE_BYTES)
            addr_q <= {addr_q[15:0], evt.data};
      end
   end

   // sequencer: run, suspend, resume, and the reset command
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         state_q                <= fsr_pkg::ST_IDLE;
         cnt_q                  <= '0;
         prog_rem_q             <= '0;
         erase_rem_q            <= '0;
         run_prog_q             <= 1'b0;
         erase_sec_q            <= '0;
         prog_sec_q             <= '0;
         PROGRAM_SUSPENDED_FLAG <= fsr_pkg::FLAG_RST;
         ERASE_SUSPENDED_FLAG   <= fsr_pkg::FLAG_RST;
         ERASE_BLOCK_UNDEF      <= 1'b0;
         PROG_PAGE_UNDEF        <= 1'b0;
      end
      else
      begin
         ERASE_BLOCK_UNDEF <= 1'b0;
         PROG_PAGE_UNDEF   <= 1'b0;
         case (state_q)
            fsr_pkg::ST_IDLE:
            begin
               if (exec && allowed)
               begin
                  if (op_q == fsr_pkg::OP_RESET)
                  begin
                     // suspended work is dropped, its area left undefined
                     ERASE_BLOCK_UNDEF      <= ERASE_SUSPENDED_FLAG;
                     PROG_PAGE_UNDEF        <= PROGRAM_SUSPENDED_FLAG;
                     ERASE_SUSPENDED_FLAG   <= 1'b0;
                     PROGRAM_SUSPENDED_FLAG <= 1'b0;
                  end
                  else if (op_q == fsr_pkg::OP_RESUME)
                  begin
                     // nested case: the program goes first
                     if (PROGRAM_SUSPENDED_FLAG || ERASE_SUSPENDED_FLAG)
                     begin
                        state_q    <= fsr_pkg::ST_RESUME;
                        run_prog_q <= PROGRAM_SUSPENDED_FLAG;
                        cnt_q      <= CW'(fsr_pkg::RESUME_LATENCY_CYC);
                     end
                  end
                  else if (is_prog(op_q) && WRITE_ENABLE_LATCH &&
                           nb_q >= fsr_pkg::PROG_MIN_BYTES &&
                           !(ERASE_SUSPENDED_FLAG && cmd_sec == erase_sec_q))
                  begin
                     state_q    <= fsr_pkg::ST_PROG;
                     run_prog_q <= 1'b1;
                     prog_sec_q <= cmd_sec;
                     cnt_q      <= CW'(PROG_CYCLES);
                  end
                  else if (is_erase(op_q) && WRITE_ENABLE_LATCH &&
                           nb_q >= fsr_pkg::ADDR_DONE_BYTES)
                  begin
                     state_q     <= fsr_pkg::ST_ERASE;
                     run_prog_q  <= 1'b0;
                     erase_sec_q <= cmd_sec;
                     cnt_q       <= erase_len(op_q);
                  end
               end
            end
            fsr_pkg::ST_PROG, fsr_pkg::ST_ERASE:
            begin
               // suspend needs no write enable; trailing bytes are ignored
               if (exec && op_q == fsr_pkg::OP_SUSPEND)
               begin
                  state_q <= fsr_pkg::ST_SUSP;
                  cnt_q   <= CW'(fsr_pkg::SUSPEND_LATENCY_CYC);
                  if (run_prog_q)
                     prog_rem_q <= cnt_q;
                  else
                     erase_rem_q <= cnt_q;
               end
               else if (cnt_q <= 1)
               begin
                  state_q <= fsr_pkg::ST_IDLE;
                  cnt_q   <= '0;
               end
               else
                  cnt_q <= cnt_q - 1'b1;
            end
            fsr_pkg::ST_SUSP:
            begin
               // work is frozen; the flag appears when the latency ends
               if (cnt_q <= 1)
               begin
                  state_q <= fsr_pkg::ST_IDLE;
                  cnt_q   <= '0;
                  if (run_prog_q)
                     PROGRAM_SUSPENDED_FLAG <= 1'b1;
                  else
                     ERASE_SUSPENDED_FLAG <= 1'b1;
               end
               else
                  cnt_q <= cnt_q - 1'b1;
            end
            fsr_pkg::ST_RESUME:
            begin
               // suspend commands fall through unheard here
               if (cnt_q <= 1)
               begin
                  if (run_prog_q)
                  begin
                     state_q                <= fsr_pkg::ST_PROG;
                     cnt_q                  <= prog_rem_q;
                     PROGRAM_SUSPENDED_FLAG <= 1'b0;
                  end
                  else
                  begin
                     state_q              <= fsr_pkg::ST_ERASE;
                     cnt_q                <= erase_rem_q;
                     ERASE_SUSPENDED_FLAG <= 1'b0;
                  end
               end
               else
                  cnt_q <= cnt_q - 1'b1;
            end
            default:
            begin
               state_q <= fsr_pkg::ST_IDLE;
               cnt_q   <= '0;
            end
         endcase
      end
   end

   // write enable latch; refused commands leave it untouched, except an erase to the program-suspended sector, which clears it
   always_ff @(posedge CLK)
   begin
      if (RST)
         WRITE_ENABLE_LATCH <= fsr_pkg::WEL_RST;
      else if (exec && idle)
      begin
         if (is_erase(op_q) && PROGRAM_SUSPENDED_FLAG && cmd_sec == prog_sec_q)
            WRITE_ENABLE_LATCH <= 1'b0;
         else if (!allowed)
            WRITE_ENABLE_LATCH <= WRITE_ENABLE_LATCH;
         else if (op_q == fsr_pkg::OP_WREN)
            WRITE_ENABLE_LATCH <= 1'b1;
         else if (op_q == fsr_pkg::OP_WRDI)
            WRITE_ENABLE_LATCH <= 1'b0;
         else if (is_prog(op_q) || is_erase(op_q))
            WRITE_ENABLE_LATCH <= 1'b0;
      end
   end

   // ready/busy: high while work runs, halts or restarts
   always_ff @(posedge CLK)
   begin
      if (RST)
         READY_BUSY_FLAG <= 1'b0;
      else
         READY_BUSY_FLAG <= ~idle;
   end

   // read address tracking; reads are refused while the array is busy
   always_ff @(posedge CLK)
   begin
      if (RST || evt.frame_end)
      begin
         READ_ACTIVE <= 1'b0;
         READ_ADDR   <= '0;
      end
      else if (evt.byte_vld)
      begin
         if (nb_q == 3'h3 && is_read(op_q) && idle)
         begin
            READ_ACTIVE <= 1'b1;
            READ_ADDR   <= {addr_q[15:0], evt.data};
         end
         else if (READ_ACTIVE)
            READ_ADDR <= READ_ADDR + 1'b1;
      end
   end

   // undefined data while the counter sits in a suspended sector
   always_ff @(posedge CLK)
   begin
      if (RST)
         READ_DATA_UNDEF <= 1'b0;
      else
         READ_DATA_UNDEF <= READ_ACTIVE &
            ((ERASE_SUSPENDED_FLAG &&
              READ_ADDR[fsr_pkg::ADDR_W-1:fsr_pkg::SECTOR_LSB] == erase_sec_q) ||
             (PROGRAM_SUSPENDED_FLAG &&
              READ_ADDR[fsr_pkg::ADDR_W-1:fsr_pkg::SECTOR_LSB] == prog_sec_q));
   end

   // other legal commands go to the rest of the device; status reads
   // are passed even while busy so the host can poll
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         CMD_PASS        <= 1'b0;
         CMD_PASS_OPCODE <= 8'h00;
      end
      else
      begin
         CMD_PASS <= exec && ((idle && allowed && !is_prog(op_q) &&
                     !is_erase(op_q) && op_q != fsr_pkg::OP_SUSPEND &&
                     op_q != fsr_pkg::OP_RESUME && op_q != fsr_pkg::OP_WREN &&
                     op_q != fsr_pkg::OP_WRDI && op_q != fsr_pkg::OP_RESET) ||
                     op_q == fsr_pkg::OP_RD_STATUS);
         if (exec)
            CMD_PASS_OPCODE <= op_q;
      end
   end

endmodule : fsr_seq

`default_nettype wire

// *** fsr_seq_props.sv ***
// fsr_seq_props: concurrent checks on the sequencer's top ports.
// assumes it is bound to fsr_seq and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module fsr_seq_props
(
   // clock and reset
   input wire logic                      CLK,
   input wire logic                      RST,
   // serial pins
   input wire logic                      SCK,
   input wire logic                      CS_N,
   input wire logic                      SI,
   // flags
   input wire logic                      WRITE_ENABLE_LATCH,
   input wire logic                      PROGRAM_SUSPENDED_FLAG,
   input wire logic                      ERASE_SUSPENDED_FLAG,
   input wire logic                      READY_BUSY_FLAG,
   // read, pass and cancel
   input wire logic                      READ_ACTIVE,
   input wire logic [fsr_pkg::ADDR_W-1:0] READ_ADDR,
   input wire logic                      READ_DATA_UNDEF,
   input wire logic                      CMD_PASS,
   input wire logic [7:0]                CMD_PASS_OPCODE,
   input wire logic                      ERASE_BLOCK_UNDEF,
   input wire logic                      PROG_PAGE_UNDEF
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // commands act only after the frame closed, pulses are single
   a_pass_pulse: assert property (CMD_PASS |=> !CMD_PASS)
      else $error("pass pulse too long");
   a_pass_frame: assert property (CMD_PASS |-> CS_N && $past(CS_N))
      else $error("pass inside a frame");
   a_blk_cancel: assert property (ERASE_BLOCK_UNDEF |=>
      !ERASE_BLOCK_UNDEF && !ERASE_SUSPENDED_FLAG) else $error("erase cancel bad");
   a_page_cancel: assert property (PROG_PAGE_UNDEF |=>
      !PROG_PAGE_UNDEF && !PROGRAM_SUSPENDED_FLAG) else $error("program cancel bad");
   // a suspend that lands leaves the device ready within two cycles
   a_susp_ready: assert property ($rose(PROGRAM_SUSPENDED_FLAG) ||
      $rose(ERASE_SUSPENDED_FLAG) |-> ##[0:2] !READY_BUSY_FLAG) else $error("not ready");
   a_wel_frame: assert property ($changed(WRITE_ENABLE_LATCH) |-> CS_N)
      else $error("latch moved inside a frame");
   a_wel_psusp: assert property ($rose(WRITE_ENABLE_LATCH) |->
      !PROGRAM_SUSPENDED_FLAG) else $error("latch set in program suspend");
   a_undef_read: assert property (READ_DATA_UNDEF |->
      $past(PROGRAM_SUSPENDED_FLAG) || $past(ERASE_SUSPENDED_FLAG))
      else $error("undef, none held");
   // a flag clears by resume (busy) or by a reset cancel pulse
   a_ps_clear: assert property ($fell(PROGRAM_SUSPENDED_FLAG) |-> READY_BUSY_FLAG ||
      PROG_PAGE_UNDEF || $past(PROG_PAGE_UNDEF)) else $error("program flag lost");
   a_es_clear: assert property ($fell(ERASE_SUSPENDED_FLAG) |-> READY_BUSY_FLAG ||
      ERASE_BLOCK_UNDEF || $past(ERASE_BLOCK_UNDEF)) else $error("erase flag lost");
endmodule : fsr_seq_props
bind fsr_seq fsr_seq_props i_fsr_seq_props (.CLK(CLK), .RST(RST), .SCK(SCK),
   .CS_N(CS_N), .SI(SI), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
   .PROGRAM_SUSPENDED_FLAG(PROGRAM_SUSPENDED_FLAG), .ERASE_SUSPENDED_FLAG(ERASE_SUSPENDED_FLAG),
   .READY_BUSY_FLAG(READY_BUSY_FLAG), .READ_ACTIVE(READ_ACTIVE), .READ_ADDR(READ_ADDR),
   .READ_DATA_UNDEF(READ_DATA_UNDEF), .CMD_PASS(CMD_PASS), .CMD_PASS_OPCODE(CMD_PASS_OPCODE),
   .ERASE_BLOCK_UNDEF(ERASE_BLOCK_UNDEF), .PROG_PAGE_UNDEF(PROG_PAGE_UNDEF));
`default_nettype wire

// *** fsr_seq_tb.sv ***
// fsr_seq_tb: self-checking bench for the suspend/resume sequencer.
// assumes fsr_spi_host drives the serial pins; work times are shortened.
`timescale 1ns/100ps
`default_nettype none
module fsr_seq_tb;
   localparam int PC = 8000;
   localparam int EC = 16000;
   logic clk, rst, sck, cs_n, si, write_enable_latch, ps, es, bsy, ract, rund, cpass, bund, pund, av, bv, pact;
   logic [23:0] raddr, prev, last;
   logic [7:0]  cop, sa, sb, npass, nblk, npage, n0;
   int          num_errors, num_checks, seed, cyc;
   logic [7:0]  rej [5] = '{8'h60, 8'hc7, 8'h36, 8'h39, fsr_pkg::OP_ERASE_64K};
   logic [7:0]  acc [5] = '{fsr_pkg::OP_RD_PROT, fsr_pkg::OP_RD_LOCK, fsr_pkg::OP_RD_OTP,
                            fsr_pkg::OP_RD_STATUS, fsr_pkg::OP_RD_ID};
   logic [7:0]  gop [3] = '{fsr_pkg::OP_ERASE_32K, fsr_pkg::OP_ERASE_64K, fsr_pkg::OP_PROG_DUAL};
   fsr_seq #(.PROG_CYCLES(PC), .ERASE_4K_CYCLES(EC), .ERASE_32K_CYCLES(EC),
      .ERASE_64K_CYCLES(EC)) i_fsr_seq (.CLK(clk), .RST(rst), .SCK(sck), .CS_N(cs_n),
      .SI(si), .WRITE_ENABLE_LATCH(write_enable_latch), .PROGRAM_SUSPENDED_FLAG(ps),
      .ERASE_SUSPENDED_FLAG(es), .READY_BUSY_FLAG(bsy), .READ_ACTIVE(ract),
      .READ_ADDR(raddr), .READ_DATA_UNDEF(rund), .CMD_PASS(cpass), .CMD_PASS_OPCODE(cop),
      .ERASE_BLOCK_UNDEF(bund), .PROG_PAGE_UNDEF(pund));
   fsr_spi_host i_fsr_spi_host (.sck(sck), .cs_n(cs_n), .si(si));
   // 200 MHz core clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   function automatic logic [7:0] fl();
      return {4'h0, write_enable_latch, ps, es, bsy};
   endfunction : fl
   // undefined when the sector is one the bench holds as suspended
   function automatic logic [7:0] eu(input logic [23:0] a);
      return {7'h0, (av && a[23:16] == sa) || (bv && a[23:16] == sb)};
   endfunction : eu
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   // one frame, random trailing bytes, then let it execute
   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n);
      i_fsr_spi_host.xfer({op, a, $random(seed)}, n);
      wt(20);
   endtask : cmd
   // wait for the work to finish, bounded
   task automatic wb();
      for (int i = 0; i < 40000 && bsy !== 1'b0; i++) @(posedge clk);
   endtask : wb
   // cycle limit, pulse counts and read data check; the limit guards hangs
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      npass <= npass + {7'h0, cpass === 1'b1};
      nblk  <= nblk + {7'h0, bund === 1'b1};
      npage <= npage + {7'h0, pund === 1'b1};
      if (ract === 1'b1 && pact)
         chk("undef", eu(prev), {7'h0, rund});
      pact <= ract === 1'b1;
      prev <= raddr;
      // last address reached by a read, checked once the frame is over
      if (ract === 1'b1)
         last <= raddr;
      if (cyc == 95000)
      begin
         num_errors++;
         end_sim();
      end
   end
   initial
   begin
      {seed, num_errors, num_checks, cyc} = {32'd88611, 96'h0};
      {npass, nblk, npage, av, bv, pact, prev, rst} = {24'h0, 3'h0, 24'h0, 1'b1};
      wt(6);
      rst <= 1'b0;
      wt(4);
      chk("flags", 8'h00, fl());
      cmd(fsr_pkg::OP_WREN, 24'h0, 8);
      chk("flags", 8'h08, fl());
      cmd(fsr_pkg::OP_ERASE_4K, {8'h21, 16'($random(seed))}, 32);
      chk("flags", 8'h01, fl());
      cmd(fsr_pkg::OP_SUSPEND, 24'h0, 12);
      wt(4100);
      chk("flags", 8'h01, fl());
      cmd(fsr_pkg::OP_SUSPEND, 24'h0, 16);
      wt(4100);
      chk("flags", 8'h02, fl());
      {av, sa} = {1'b1, 8'h21};
      cmd(fsr_pkg::OP_READ, 24'h20fffe, 64);
      chk("rsec", 8'h21, last[23:16]);
      chk("rlow", 8'h02, last[7:0]);
      cmd(fsr_pkg::OP_READ_FAST, 24'h21fffe, 64);
      chk("rsec", 8'h22, last[23:16]);
      cmd(fsr_pkg::OP_WREN, 24'h0, 8);
      chk("flags", 8'h0a, fl());
      cmd(fsr_pkg::OP_WRDI, 24'h0, 8);
      chk("flags", 8'h02, fl());
      cmd(fsr_pkg::OP_WREN, 24'h0, 8);
      cmd(fsr_pkg::OP_PROG, 24'h210000, 40);
      chk("flags", 8'h02, fl());
      cmd(fsr_pkg::OP_WREN, 24'h0, 8);
      cmd(fsr_pkg::OP_PROG, {8'h22, 16'($random(seed))}, 40);
      chk("flags", 8'h03, fl());
      cmd(fsr_pkg::OP_SUSPEND, 24'h0, 8);
      wt(4100);
      chk("flags", 8'h06, fl());
      {bv, sb} = {1'b1, 8'h22};
      cmd(fsr_pkg::OP_WREN, 24'h0, 8);
      chk("flags", 8'h06, fl());
      n0 = npass;
      foreach (rej[i]) cmd(rej[i], 24'h220000, 32);
      chk("pass", n0, npass);
      chk("flags", 8'h06, fl());
      foreach (acc[i]) cmd(acc[i], 24'h0, 32);
      chk("pass", n0 + 8'h05, npass);
      chk("opcode", fsr_pkg::OP_RD_ID, cop);
      cmd(fsr_pkg::OP_RESUME, 24'h0, 5);
      wt(4100);
      chk("flags", 8'h06, fl());
      cmd(fsr_pkg::OP_RESUME, 24'h0, 16);
      chk("flags", 8'h07, fl());
      cmd(fsr_pkg::OP_SUSPEND, 24'h0, 8); // deliberately inside the resume time
      wt(4100);
      chk("flags", 8'h03, fl());
      bv = 1'b0;
      wb();
      chk("flags", 8'h02, fl());
      cmd(fsr_pkg::OP_RESUME, 24'h0, 8); // second resume once program is done
      wt(4100); // full resume time before anything else
      chk("flags", 8'h01, fl());
      av = 1'b0;
      wb();
      foreach (gop[i])
      begin
         cmd(fsr_pkg::OP_WREN, 24'h0, 8);
         cmd(gop[i], 24'h300000, 40);
         chk("flags", 8'h01, fl());
         cmd(fsr_pkg::OP_SUSPEND, 24'h0, 8);
         wt(4100);
         cmd(fsr_pkg::OP_RESET, 24'h0, 8);
         chk("flags", 8'h00, fl());
      end
      chk("blk", 8'h02, nblk);
      chk("page", 8'h01, npage);
      end_sim();
   end
endmodule : fsr_seq_tb
`default_nettype wire

// *** fsr_spi_host.sv ***
// fsr_spi_host: behavioural spi host, mode 0, 64 ns serial clock.
// assumes the bench calls xfer and leaves the frame gap to this model.
`timescale 1ns/100ps
`default_nettype none
module fsr_spi_host
(
   // serial pins
   output logic sck,
   output logic cs_n,
   output logic si
);
   // idle: clock stands low, select high
   initial
   begin
      sck  = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end
   // whole frame msb first, opcode in the top byte
   task automatic xfer(input logic [63:0] d, input int n);
      cs_n = 1'b0;
      #40;
      for (int i = 0; i < n; i++)
      begin
         si = d[63-i];
         #32 sck = 1'b1;
         #32 sck = 1'b0;
      end
      #40 cs_n = 1'b1;
      si = ~si; // released line must not show the last bit
      #100;
   endtask : xfer
endmodule : fsr_spi_host
`default_nettype wire

// *** fsr_spi_rx.sv ***
// fsr_spi_rx: samples the serial pins on the core clock and turns them
// into byte and end-of-frame events.
// assumes spi mode 0 or 3 with the serial clock well below core rate.
`timescale 1ns/100ps
`default_nettype none

module fsr_spi_rx
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // raw pins
   input  wire logic                 sck,
   input  wire logic                 cs_n,
   input  wire logic                 si,
   // events
   output fsr_pkg::fsr_spi_evt_s     evt_q
);

   logic [2:0] sck_q;
   logic [1:0] si_q;
   logic [2:0] cs_q;
   logic [2:0] bit_cnt_q;
   logic [6:0] shift_q;
   logic       sck_rise;
   logic       cs_rise;

   // two-flop synchronisers, third stage only for edge finding
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sck_q <= 3'h0;
         si_q  <= 2'h0;
         cs_q  <= 3'h7;
      end
      else
      begin
         sck_q <= {sck_q[1:0], sck};
         si_q  <= {si_q[0], si};
         cs_q  <= {cs_q[1:0], cs_n};
      end
   end

   assign sck_rise = sck_q[1] & ~sck_q[2];
   assign cs_rise  = cs_q[1] & ~cs_q[2];

   // bit assembly; the count clears while deselected
   always_ff @(posedge clk)
   begin
      if (rst || cs_q[1])
      begin
         bit_cnt_q <= 3'h0;
         shift_q   <= 7'h00;
      end
      else if (sck_rise)
      begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shift_q   <= {shift_q[5:0], si_q[1]};
      end
   end

   // events: frame end never shares a cycle with a byte
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         evt_q <= '0;
      end
      else
      begin
         evt_q.byte_vld  <= ~cs_q[1] & sck_rise & (bit_cnt_q == 3'h7);
         evt_q.data      <= {shift_q, si_q[1]};
         evt_q.frame_end <= cs_rise;
         evt_q.aligned   <= (bit_cnt_q == 3'h0);
      end
   end

endmodule : fsr_spi_rx

`default_nettype wire
